// [rtl/tsr_pkg.sv]
// Package for the temperature sensor register pointer and serial target.
// Assumes a single 100 MHz clock and a two-wire bus sampled synchronously.
package tsr_pkg;

  // Pointer codes selecting the four data registers
  localparam logic [1:0] PTR_TEMPERATURE = 2'h0;
  localparam logic [1:0] PTR_SETTINGS = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // Pointer register layout
  localparam int PTR_SEL_LSB = 0;
  localparam int PTR_SEL_W = 2;
  localparam logic [5:0] PTR_UPPER_BITS = 6'h00;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // Reset values of the data registers
  localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
  localparam logic [15:0] SETTINGS_RESET = 16'h40A0;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] UPPER_RESET = 16'h0000;

  // Writable bits of the settings word; the rest keep their reset value
  localparam logic [15:0] SETTINGS_WR_MASK = 16'h9FC0;

  // Bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_POINTER = 2'h0;
  localparam logic [1:0] IDX_MSB = 2'h1;
  localparam logic [1:0] IDX_LSB = 2'h2;

  typedef enum logic [2:0] {
    TSR_IDLE = 3'h0,
    TSR_ADDR = 3'h1,
    TSR_ACK_ADDR = 3'h3,
    TSR_RX = 3'h2,
    TSR_ACK_RX = 3'h6,
    TSR_TX = 3'h7,
    TSR_ACK_TX = 3'h5
  } tsr_state_e;

  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] settings;
    logic [15:0] lower;
    logic [15:0] upper;
  } tsr_regs_s;

  typedef struct packed {
    tsr_state_e st;
    logic scl_p;
    logic sda_p;
    logic [7:0] shift;
    logic [3:0] bits;
    logic rw;
    logic [1:0] idx;
    logic [7:0] msb;
    logic [15:0] tx;
    logic half;
    logic sda_oe;
    logic sda_o;
    logic [1:0] ptr;
    tsr_regs_s regs;
  } tsr_state_s;

endpackage

// [rtl/tsr_target.sv]
// Two-wire bus target with pointer register and four 16-bit data registers.
// Assumes scl/sda arrive synchronous to mclk and an external wire resolves sda_oe.

// Summary of operation
// RULE1: Eight-bit pointer register; only its two low bits are writable and select.
// RULE2: Pointer bits two to seven read as zero and ignore written values.
// RULE3: Pointer 0 temperature, 1 settings, 2 lower limit, 3 upper limit.
// RULE4: Host loads the pointer before any data access.
// RULE5: Temperature is read only; settings and both limits are read and write.
// RULE6: Only the pointer chooses which data register an access reaches.
// RULE7: All registers are reached over the two-wire bus, device as target.
// RULE8: Sixteen-bit words travel most significant byte first.
// RULE9: Pointer holds between accesses and resets to zero, temperature selected.
module tsr_target (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [6:0] target_addr,
  input wire logic temp_load,
  input wire logic [15:0] temp_data,
  output logic [7:0] register_pointer,
  output logic [15:0] temperature_result,
  output logic [15:0] settings_word,
  output logic [15:0] lower_limit,
  output logic [15:0] upper_limit
);

  tsr_pkg::tsr_state_s q;
  tsr_pkg::tsr_state_s d;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [15:0] sel_word;
  logic [15:0] wr_word;

  assign scl_rise = scl_i && !q.scl_p;
  assign scl_fall = !scl_i && q.scl_p;
  assign start_seen = scl_i && q.scl_p && q.sda_p && !sda_i;
  assign stop_seen = scl_i && q.scl_p && !q.sda_p && sda_i;

  // Register chosen by the pointer alone
  always_comb begin
    case (q.ptr) // see RULE3 see RULE6
      tsr_pkg::PTR_TEMPERATURE: sel_word = q.regs.temperature;
      tsr_pkg::PTR_SETTINGS: sel_word = q.regs.settings;
      tsr_pkg::PTR_LOWER: sel_word = q.regs.lower;
      tsr_pkg::PTR_UPPER: sel_word = q.regs.upper;
      default: sel_word = q.regs.temperature;
    endcase
  end

  // MSB byte was held; current shift holds the LSB
  assign wr_word = {q.msb, q.shift}; // see RULE8

  always_comb begin
    d = q;
    d.scl_p = scl_i;
    d.sda_p = sda_i;
    d.sda_o = 1'b0;
    if (temp_load) begin
      d.regs.temperature = temp_data;
    end
    if (start_seen) begin // see RULE7
      d.st = tsr_pkg::TSR_ADDR;
      d.bits = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      d.st = tsr_pkg::TSR_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        tsr_pkg::TSR_IDLE: begin
          d.sda_oe = 1'b0;
        end
        tsr_pkg::TSR_ADDR: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda_i};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == tsr_pkg::BITS_PER_BYTE) begin
            if (q.shift[7:1] == target_addr) begin
              d.rw = q.shift[0];
              d.sda_oe = 1'b1;
              d.st = tsr_pkg::TSR_ACK_ADDR;
            end else begin
              d.st = tsr_pkg::TSR_IDLE;
            end
          end
        end
        tsr_pkg::TSR_ACK_ADDR: begin
          if (scl_fall) begin
            d.bits = 4'h0;
            if (q.rw) begin
              // Whole word latched so both bytes come from one sample
              d.tx = sel_word; // see RULE4 see RULE6
              d.half = 1'b0;
              d.sda_oe = !sel_word[15]; // see RULE8
              d.st = tsr_pkg::TSR_TX;
            end else begin
              d.idx = tsr_pkg::IDX_POINTER;
              d.sda_oe = 1'b0;
              d.st = tsr_pkg::TSR_RX;
            end
          end
        end
        tsr_pkg::TSR_RX: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda_i};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == tsr_pkg::BITS_PER_BYTE) begin
            d.sda_oe = 1'b1;
            d.st = tsr_pkg::TSR_ACK_RX;
            case (q.idx)
              tsr_pkg::IDX_POINTER: begin
                // Upper six bits dropped
                d.ptr = q.shift[tsr_pkg::PTR_SEL_LSB +: tsr_pkg::PTR_SEL_W]; // see RULE1 see RULE2
                d.idx = tsr_pkg::IDX_MSB;
              end
              tsr_pkg::IDX_MSB: begin
                d.msb = q.shift; // see RULE8
                d.idx = tsr_pkg::IDX_LSB;
              end
              tsr_pkg::IDX_LSB: begin
                case (q.ptr) // see RULE5 see RULE6
                  tsr_pkg::PTR_SETTINGS: begin
                    d.regs.settings = (wr_word & tsr_pkg::SETTINGS_WR_MASK)
                      | (q.regs.settings & ~tsr_pkg::SETTINGS_WR_MASK);
                  end
                  tsr_pkg::PTR_LOWER: d.regs.lower = wr_word;
                  tsr_pkg::PTR_UPPER: d.regs.upper = wr_word;
                  default: d.regs = d.regs;
                endcase
                // Further word pairs go to the same register
                d.idx = tsr_pkg::IDX_MSB;
              end
              default: d.idx = tsr_pkg::IDX_MSB;
            endcase
          end
        end
        tsr_pkg::TSR_ACK_RX: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bits = 4'h0;
            d.st = tsr_pkg::TSR_RX;
          end
        end
        tsr_pkg::TSR_TX: begin
          if (scl_rise) begin
            d.bits = q.bits + 4'h1;
          end else if (scl_fall) begin
            d.tx = {q.tx[14:0], 1'b0};
            if (q.bits == tsr_pkg::BITS_PER_BYTE) begin
              d.sda_oe = 1'b0;
              d.st = tsr_pkg::TSR_ACK_TX;
            end else begin
              d.sda_oe = !q.tx[14];
            end
          end
        end
        tsr_pkg::TSR_ACK_TX: begin
          if (scl_rise && sda_i) begin
            // Not acknowledged: stay off the bus until the next start
            d.st = tsr_pkg::TSR_IDLE;
          end else if (scl_fall) begin
            d.bits = 4'h0;
            d.half = !q.half;
            d.st = tsr_pkg::TSR_TX;
            if (q.half) begin
              // Repeat the same register, MSB first again
              d.tx = sel_word; // see RULE8
              d.sda_oe = !sel_word[15];
            end else begin
              d.sda_oe = !q.tx[15];
            end
          end
        end
        default: begin
          d.st = tsr_pkg::TSR_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q.st <= tsr_pkg::TSR_IDLE;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.shift <= 8'h00;
      q.bits <= 4'h0;
      q.rw <= 1'b0;
      q.idx <= tsr_pkg::IDX_POINTER;
      q.msb <= 8'h00;
      q.tx <= 16'h0000;
      q.half <= 1'b0;
      q.sda_oe <= 1'b0;
      q.sda_o <= 1'b0;
      q.ptr <= tsr_pkg::PTR_RESET; // see RULE9
      q.regs.temperature <= tsr_pkg::TEMPERATURE_RESET;
      q.regs.settings <= tsr_pkg::SETTINGS_RESET;
      q.regs.lower <= tsr_pkg::LOWER_RESET;
      q.regs.upper <= tsr_pkg::UPPER_RESET;
    end else begin
      q <= d;
    end
  end

  assign sda_o = q.sda_o;
  assign sda_oe = q.sda_oe;
  assign register_pointer = {tsr_pkg::PTR_UPPER_BITS, q.ptr}; // see RULE2
  assign temperature_result = q.regs.temperature;
  assign settings_word = q.regs.settings;
  assign lower_limit = q.regs.lower;
  assign upper_limit = q.regs.upper;

endmodule

// [test/tsr_host.sv]
// Bus host model: clocks the bus and pulls data low.
// Assumes a pull-up on data; the bus clock idles high between frames.
module tsr_host (
  input wire logic mclk,
  output logic scl,
  output logic oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    oe = 1'b0;
  end
  task automatic hw();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    oe = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    oe = 1'b1;
    hw();
    scl = 1'b0;
  endtask
  task automatic stop();
    oe = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    oe = 1'b0;
    hw();
  endtask
  task automatic bitx(input logic b, output logic r);
    oe = !b;
    hw();
    scl = 1'b1;
    hw();
    r = sda;
    hw();
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(last, ack);
  endtask
endmodule

// [test/tsr_checker.sv]
// Checker for the pointer target, bound to tsr_target.
// Assumes one clock domain.
module tsr_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_i,
  input logic sda_o,
  input logic sda_oe,
  input wire logic temp_load,
  input wire logic [15:0] temp_data,
  input logic [7:0] register_pointer,
  input logic [15:0] temperature_result,
  input logic [15:0] settings_word,
  input logic [15:0] lower_limit,
  input logic [15:0] upper_limit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  AST_PTR_ZERO: assert property (register_pointer[7:2] == tsr_pkg::PTR_UPPER_BITS)
    else $error("pointer upper bits set");
  AST_PTR_PHASE: assert property (!$stable(register_pointer) |-> !scl_i)
    else $error("pointer moved in clock high");
  AST_OE_PHASE: assert property (!$stable(sda_oe) |-> !scl_i)
    else $error("data changed in clock high");
  AST_DRIVE_LOW: assert property (sda_o == 1'b0)
    else $error("data driven high");
  AST_TEMP_LOAD: assert property (temp_load |=> temperature_result == $past(temp_data))
    else $error("temperature not loaded");
  AST_TEMP_RO: assert property (!$stable(temperature_result) |-> $past(temp_load))
    else $error("temperature changed by bus");
  AST_CFG_FIXED: assert property ((settings_word & ~tsr_pkg::SETTINGS_WR_MASK) ==
    (tsr_pkg::SETTINGS_RESET & ~tsr_pkg::SETTINGS_WR_MASK)) else $error("fixed settings bits moved");
  AST_CFG_SEL: assert property (!$stable(settings_word) |-> register_pointer[1:0] == tsr_pkg::PTR_SETTINGS)
    else $error("settings written off pointer");
  AST_LOWER_SEL: assert property (!$stable(lower_limit) |-> register_pointer[1:0] == tsr_pkg::PTR_LOWER)
    else $error("lower written off pointer");
  AST_UPPER_SEL: assert property (!$stable(upper_limit) |-> register_pointer[1:0] == tsr_pkg::PTR_UPPER)
    else $error("upper written off pointer");
  cover property (temp_load);
  cover property (!$stable(register_pointer));
  cover property (!$stable(upper_limit));
endmodule
bind tsr_target tsr_checker chk (.mclk(mclk), .reset(reset), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .temp_load(temp_load), .temp_data(temp_data), .register_pointer(register_pointer),
  .temperature_result(temperature_result), .settings_word(settings_word), .lower_limit(lower_limit),
  .upper_limit(upper_limit));

// [test/temp_sensor_register_pointer_bench.sv]
// Bench: random register traffic through the bus host model.
// Assumes tsr_host and the bound checker.
module temp_sensor_register_pointer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h2A;
  // Full run is under 9000 bus-driven cycles; generous margin
  localparam int WATCHDOG_CYCLES = 30000;
  logic mclk, reset, temp_load, sda_oe, sda_o, scl, h_oe, ack;
  logic [15:0] temp_data, tres, sw, ll, ul, q, q2, m[4];
  logic [7:0] ptr, b;
  logic [31:0] rs = 32'hEA9692E1, r;
  int n_mismatch = 0, samples_checked = 0;
  wire sda = !(sda_oe || h_oe);
  tsr_target dut (.mclk(mclk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .target_addr(ADDR), .temp_load(temp_load), .temp_data(temp_data), .register_pointer(ptr),
    .temperature_result(tres), .settings_word(sw), .lower_limit(ll), .upper_limit(ul));
  tsr_host host (.mclk(mclk), .scl(scl), .oe(h_oe), .sda(sda));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [15:0] upd(input logic [1:0] p, input logic [15:0] d);
    if (p == tsr_pkg::PTR_TEMPERATURE) return m[0];
    if (p == tsr_pkg::PTR_SETTINGS)
      return (d & tsr_pkg::SETTINGS_WR_MASK) | (tsr_pkg::SETTINGS_RESET & ~tsr_pkg::SETTINGS_WR_MASK);
    return d;
  endfunction
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_ack(input string s, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic put(input logic [7:0] d);
    host.xfer(d, 1'b1, b, ack);
    chk_ack("ack", 1'b0, ack);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    host.start();
    put({ADDR, 1'b0});
    put(p);
    put(d[15:8]);
    put(d[7:0]);
    host.stop();
  endtask
  // Optionally acks the first word's LSB and reads the same register again
  task automatic rd(input logic rep);
    host.start();
    put({ADDR, 1'b1});
    host.xfer(8'hFF, 1'b0, q[15:8], ack);
    host.xfer(8'hFF, !rep, q[7:0], ack);
    if (rep) begin
      host.xfer(8'hFF, 1'b0, q2[15:8], ack);
      host.xfer(8'hFF, 1'b1, q2[7:0], ack);
    end
    host.stop();
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  initial begin
    repeat (WATCHDOG_CYCLES) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    temp_load = 1'b0;
    temp_data = 16'h0000;
    m = '{tsr_pkg::TEMPERATURE_RESET, tsr_pkg::SETTINGS_RESET, tsr_pkg::LOWER_RESET, tsr_pkg::UPPER_RESET};
    repeat (8) @(posedge mclk);
    #1 reset = 1'b0;
    chk("ptr", 16'h0000, {8'h00, ptr});
    chk("cfg", m[1], sw);
    chk("low", m[2], ll);
    chk("up", m[3], ul);
    r = xs();
    @(posedge mclk);
    #1 temp_load = 1'b1;
    temp_data = r[15:0];
    @(posedge mclk);
    #1 temp_load = 1'b0;
    m[0] = r[15:0];
    chk("temp", m[0], tres);
    rd(1'b0);
    chk("rd0", m[0], q);
    for (int i = 0; i < 12; i++) begin
      r = xs();
      wr({r[7:2], i[1:0]}, r[31:16]);
      chk("ptr", {14'h0000, i[1:0]}, {8'h00, ptr});
      m[i[1:0]] = upd(i[1:0], r[31:16]);
      rd(i[3]);
      chk("rd", m[i[1:0]], q);
      if (i[3]) begin
        chk("rep", m[i[1:0]], q2);
      end
      chk("lo", m[2], ll);
      chk("hi", m[3], ul);
    end
    host.start();
    host.xfer({~ADDR, 1'b0}, 1'b1, b, ack);
    host.stop();
    chk_ack("nack", 1'b1, ack);
    final_report();
  end
endmodule
